/* core/scr_smbus_slave.sv */
/*
 * Serial management bus slave: start/stop detection, address match,
 * register pointer byte, write and auto-incrementing read transfers.
 * Assumes SCL and SDA are sampled synchronously to i_core_clk, many
 * core clocks per bus bit; SDA is open drain, driven low only.
 */
`timescale 1ns/10ps
module scr_smbus_slave
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [6:0] i_own_addr,
    input wire logic [7:0] i_rd_data,
    output logic o_sda_pull,
    output logic o_wr,
    output logic [7:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic [7:0] o_ptr
);

    typedef enum logic [5:0]
    {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_ACK_A = 6'b000100,
        ST_WDATA = 6'b001000,
        ST_ACK_W = 6'b010000,
        ST_RDATA = 6'b100000
    } scr_state_e;

    scr_state_e st_q, st_d;
    logic scl_q, sda_q, scl_p, sda_p;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wa_q, wa_d, wd_q, wd_d;
    logic first_q, first_d, rw_q, rw_d, drive_q, drive_d, wr_q, wr_d;
    logic master_ack_q, master_ack_d;
    logic scl_rise, scl_fall, start, stop;

    assign scl_rise = scl_q & ~scl_p;
    assign scl_fall = ~scl_q & scl_p;
    assign start = scl_q & scl_p & sda_p & ~sda_q;
    assign stop = scl_q & scl_p & ~sda_p & sda_q;

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        wa_d = wa_q;
        wd_d = wd_q;
        first_d = first_q;
        rw_d = rw_q;
        drive_d = drive_q;
        wr_d = 1'b0;
        master_ack_d = master_ack_q;
        if (start)
        begin
            st_d = ST_ADDR;
            cnt_d = 4'h0;
            first_d = 1'b1;
            drive_d = 1'b0;
        end
        else if (stop)
        begin
            st_d = ST_IDLE;
            drive_d = 1'b0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    drive_d = 1'b0;
                end
                ST_ADDR, ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        sh_d = {sh_q[6:0], sda_q};
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (scl_fall && cnt_q == scr_pkg::BITS_PER_BYTE)
                    begin
                        drive_d = 1'b1;
                        if (st_q == ST_ADDR)
                        begin
                            // answer only our own address
                            st_d = (sh_q[7:1] == i_own_addr) ? ST_ACK_A : ST_IDLE;
                            drive_d = (sh_q[7:1] == i_own_addr);
                            rw_d = sh_q[0];
                        end
                        else
                        begin
                            st_d = ST_ACK_W;
                            first_d = 1'b0;
                            if (first_q)
                            begin
                                ptr_d = sh_q;
                            end
                            else
                            begin
                                wr_d = 1'b1;
                                wa_d = ptr_q;
                                wd_d = sh_q;
                                ptr_d = ptr_q + 8'h01;
                            end
                        end
                    end
                end
                ST_ACK_A, ST_ACK_W:
                begin
                    if (scl_fall)
                    begin
                        cnt_d = 4'h0;
                        drive_d = 1'b0;
                        st_d = ST_WDATA;
                        if (st_q == ST_ACK_A && rw_q)
                        begin
                            st_d = ST_RDATA;
                            sh_d = {i_rd_data[6:0], 1'b0};
                            drive_d = ~i_rd_data[7];
                            cnt_d = 4'h1;
                        end
                    end
                end
                ST_RDATA:
                begin
                    // cnt 9 marks the master's acknowledge slot
                    if (scl_fall && cnt_q < scr_pkg::BITS_PER_BYTE)
                    begin
                        drive_d = ~sh_q[7];
                        sh_d = {sh_q[6:0], 1'b0};
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (scl_fall && cnt_q == scr_pkg::BITS_PER_BYTE)
                    begin
                        drive_d = 1'b0;
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (scl_rise && cnt_q > scr_pkg::BITS_PER_BYTE)
                    begin
                        master_ack_d = ~sda_q;
                        if (sda_q)
                        begin
                            st_d = ST_IDLE;
                        end
                        else
                        begin
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                    else if (scl_fall && cnt_q > scr_pkg::BITS_PER_BYTE && master_ack_q)
                    begin
                        sh_d = {i_rd_data[6:0], 1'b0};
                        drive_d = ~i_rd_data[7];
                        cnt_d = 4'h1;
                    end
                end
                default:
                begin
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q <= ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            wa_q <= 8'h00;
            wd_q <= 8'h00;
            first_q <= 1'b1;
            rw_q <= 1'b0;
            drive_q <= 1'b0;
            wr_q <= 1'b0;
            master_ack_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            scl_q <= i_scl;
            sda_q <= i_sda;
            scl_p <= scl_q;
            sda_p <= sda_q;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            wa_q <= wa_d;
            wd_q <= wd_d;
            first_q <= first_d;
            rw_q <= rw_d;
            drive_q <= drive_d;
            wr_q <= wr_d;
            master_ack_q <= master_ack_d;
        end
    end

    assign o_sda_pull = drive_q;
    assign o_wr = wr_q;
    assign o_wr_addr = wa_q;
    assign o_wr_data = wd_q;
    assign o_ptr = ptr_q;

    a_foreign_addr_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (st_q == ST_ADDR && !start && !stop && scl_fall && cnt_q == 4'h8
         && sh_q[7:1] != i_own_addr) |=> (!drive_q && st_q == ST_IDLE))
        else $error("slave acknowledged a foreign address");

endmodule

/* core/scr_pkg.sv */
/*
 * Constants for the serial configuration register subset: register
 * offsets, field positions, reset values and pin 0 function codes.
 * Assumes an 8-bit register pointer and 8-bit register data.
 */
package scr_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] REG_BUS_ADDRESS = 8'h00;
    localparam logic [7:0] REG_SOFT_RESET = 8'h01;
    localparam logic [7:0] REG_PIN0_CFG = 8'h02;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 1;
    localparam int RST_TRIGGER_BIT = 0;
    localparam int CFG_MODE_MSB = 7;
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_PULL_MSB = 3;
    localparam int CFG_PULL_LSB = 2;
    localparam int CFG_IBUF_BIT = 1;
    localparam int CFG_DRIVE_BIT = 0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    // arbitrary neutral power-up bus address
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2A;
    localparam logic [7:0] PIN0_CFG_DEFAULT = 8'h05;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ****************************************************************
    // pin 0 codes
    // ****************************************************************
    localparam logic [3:0] MODE_GP_OUT = 4'h0;
    localparam logic [3:0] MODE_SIG_PRESENT = 4'h1;
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;

    // ****************************************************************
    // serial slave
    // ****************************************************************
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage

/* core/scr_top.sv */
/*
 * Configuration register subset of a deserializer: bus address,
 * soft reset trigger and general pin 0 configuration, reached over
 * the serial management bus slave.
 * Assumes bus pins synchronous to i_core_clk and an external wire
 * resolver for SDA and pin 0 from the output enables.
 */
//
// Summary of operation
// - slave address is upper seven bits of register zero; only it answers.
// - address register bit zero always reads zero; host writes zero there.
// - address field powers up at default and takes host writes.
// - writing one to reset register bit zero returns pin 0 config to power-up.
// - soft reset leaves the address register unchanged.
// - pin 0 function: 0000 output bit, 0001 signal present, others reserved.
// - pin 0 pull: 00 none, 01 pulldown default, 10 pullup, 11 reserved.
// - pin 0 config bit one enables the input buffer.
// - config bit zero enables pin output driver; default one.
`timescale 1ns/10ps
module scr_top
#(
    parameter logic [6:0] P_BUS_ADDR_DEFAULT = scr_pkg::BUS_ADDR_DEFAULT
)
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe_n,
    input wire logic i_gpout0,
    input wire logic i_signal_present0,
    output logic o_pin0_out,
    output logic o_pin0_oe_n,
    output logic o_pin0_pullup,
    output logic o_pin0_pulldown,
    output logic o_pin0_ibuf_en,
    output logic o_soft_reset
);

    // ****************************************************************
    // serial slave
    // ****************************************************************
    logic sda_pull;
    logic wr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] ptr;
    logic [7:0] rd_data;
    logic [6:0] addr_q, addr_d;

    scr_smbus_slave u_slave
    (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .i_own_addr(addr_q),
        .i_rd_data(rd_data),
        .o_sda_pull(sda_pull),
        .o_wr(wr),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_ptr(ptr)
    );

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [7:0] cfg_q, cfg_d;
    logic soft_q, soft_d;
    logic sda_oe_n_q, sda_oe_n_d;

    always_comb
    begin
        addr_d = addr_q;
        cfg_d = cfg_q;
        soft_d = 1'b0;
        sda_oe_n_d = ~sda_pull;
        if (soft_q)
        begin
            // only pin 0 config returns to power-up; bus address and slave state are kept
            cfg_d = scr_pkg::PIN0_CFG_DEFAULT;
        end
        else if (wr)
        begin
            case (wr_addr)
                scr_pkg::REG_BUS_ADDRESS:
                begin
                    // bit zero is not stored, so it stays zero
                    addr_d = wr_data[scr_pkg::ADDR_MSB:scr_pkg::ADDR_LSB];
                end
                scr_pkg::REG_SOFT_RESET:
                begin
                    // trigger self-clears; reads back as its default zero
                    soft_d = wr_data[scr_pkg::RST_TRIGGER_BIT];
                end
                scr_pkg::REG_PIN0_CFG:
                begin
                    cfg_d = wr_data;
                end
                default:
                begin
                    // unmapped offsets ignore writes
                    cfg_d = cfg_q;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            addr_q <= P_BUS_ADDR_DEFAULT;
            cfg_q <= scr_pkg::PIN0_CFG_DEFAULT;
            soft_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
        end
        else
        begin
            addr_q <= addr_d;
            cfg_q <= cfg_d;
            soft_q <= soft_d;
            sda_oe_n_q <= sda_oe_n_d;
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb
    begin
        case (ptr)
            scr_pkg::REG_BUS_ADDRESS:
            begin
                rd_data = {addr_q, 1'b0};
            end
            scr_pkg::REG_PIN0_CFG:
            begin
                rd_data = cfg_q;
            end
            default:
            begin
                // reset register reads zero: trigger is self-clearing
                rd_data = scr_pkg::READ_ZERO;
            end
        endcase
    end

    // ****************************************************************
    // pin 0 control
    // ****************************************************************
    logic [3:0] mode;
    logic [1:0] pull;
    logic pin_out_q, pin_out_d;
    logic pin_oe_n_q, pin_oe_n_d;
    logic pullup_q, pullup_d;
    logic pulldown_q, pulldown_d;
    logic ibuf_q, ibuf_d;

    assign mode = cfg_q[scr_pkg::CFG_MODE_MSB:scr_pkg::CFG_MODE_LSB];
    assign pull = cfg_q[scr_pkg::CFG_PULL_MSB:scr_pkg::CFG_PULL_LSB];

    always_comb
    begin
        // reserved function codes drive low rather than float
        case (mode)
            scr_pkg::MODE_GP_OUT:
            begin
                pin_out_d = i_gpout0;
            end
            scr_pkg::MODE_SIG_PRESENT:
            begin
                pin_out_d = i_signal_present0;
            end
            default:
            begin
                pin_out_d = 1'b0;
            end
        endcase
        // reserved pull code leaves both resistors off
        pullup_d = (pull == scr_pkg::PULL_UP);
        pulldown_d = (pull == scr_pkg::PULL_DOWN);
        ibuf_d = cfg_q[scr_pkg::CFG_IBUF_BIT];
        // host keeps buffer and driver exclusive; nothing enforced here
        pin_oe_n_d = ~cfg_q[scr_pkg::CFG_DRIVE_BIT];
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pin_out_q <= 1'b0;
            pin_oe_n_q <= 1'b0;
            pullup_q <= 1'b0;
            pulldown_q <= 1'b1;
            ibuf_q <= 1'b0;
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_n_q <= pin_oe_n_d;
            pullup_q <= pullup_d;
            pulldown_q <= pulldown_d;
            ibuf_q <= ibuf_d;
        end
    end

    assign o_sda_o = 1'b0;
    assign o_sda_oe_n = sda_oe_n_q;
    assign o_pin0_out = pin_out_q;
    assign o_pin0_oe_n = pin_oe_n_q;
    assign o_pin0_pullup = pullup_q;
    assign o_pin0_pulldown = pulldown_q;
    assign o_pin0_ibuf_en = ibuf_q;
    assign o_soft_reset = soft_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_addr_lsb_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (ptr == scr_pkg::REG_BUS_ADDRESS) |-> (rd_data[0] == 1'b0))
        else $error("address register bit zero read as one");

    a_addr_takes_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (wr && !soft_q && wr_addr == scr_pkg::REG_BUS_ADDRESS)
        |=> (addr_q == $past(wr_data[7:1])))
        else $error("bus address write not taken");

    a_soft_restores: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (wr && !soft_q && wr_addr == scr_pkg::REG_SOFT_RESET && wr_data[0])
        |=> soft_q ##1 (!soft_q && cfg_q == scr_pkg::PIN0_CFG_DEFAULT)
        ##1 (o_pin0_pulldown && !o_pin0_oe_n))
        else $error("soft reset did not restore pin configuration");

    a_soft_keeps_addr: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        soft_q |=> $stable(addr_q))
        else $error("soft reset disturbed the bus address");

    a_mode_signal: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (mode == scr_pkg::MODE_SIG_PRESENT) |=> (o_pin0_out == $past(i_signal_present0)))
        else $error("pin 0 not following signal present");

    a_pull_select: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (pull == 2'h3) |=> (!o_pin0_pullup && !o_pin0_pulldown))
        else $error("reserved pull code enabled a resistor");

    a_ibuf_gate: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        $rose(cfg_q[1]) |=> o_pin0_ibuf_en)
        else $error("input buffer enable not applied");

    a_drive_enable: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (wr && !soft_q && wr_addr == scr_pkg::REG_PIN0_CFG)
        |=> ##1 (o_pin0_oe_n == ~$past(wr_data[0], 2)))
        else $error("output driver enable mismatch");

    a_reserved_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (ptr > scr_pkg::REG_PIN0_CFG || ptr == scr_pkg::REG_SOFT_RESET)
        |-> (rd_data == 8'h00))
        else $error("reserved location read nonzero");

endmodule

/* dv/scr_host_mdl.sv */
/*
 * Bus host model: master tasks that drive SCL and pull SDA low.
 * Assumes the bench resolves SDA with a pull-up and feeds it back.
 */
`timescale 1ns/10ps
module scr_host_mdl
(
    input wire logic i_core_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe_n
);
    // ****************************************************************
    // bit timing
    // ****************************************************************
    // six clocks per half bit, above the slave's minimum of four
    localparam int HALF = 6;

    initial
    begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #2;
    endtask

    // ****************************************************************
    // framing
    // ****************************************************************
    // also serves as repeated start from a low clock
    task automatic start();
        o_sda_oe_n = 1'b1;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda_oe_n = 1'b0;
        tick(HALF);
        o_scl = 1'b0;
        tick(1);
    endtask

    task automatic stop();
        o_sda_oe_n = 1'b0;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda_oe_n = 1'b1;
        tick(HALF);
    endtask

    // data changes only while the clock is low, sampled mid-high
    task automatic clk_bit(input logic b, output logic r);
        o_sda_oe_n = b;
        tick(HALF);
        o_scl = 1'b1;
        tick(3);
        r = i_sda;
        tick(3);
        o_scl = 1'b0;
        tick(1);
    endtask

    task automatic wbyte(input logic [7:0] d, output bit ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = (r === 1'b0);
    endtask

    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(1'b1, r);
            d[i] = r;
        end
        clk_bit(nack, r);
    endtask
endmodule

/* dv/tb.sv */
/*
 * Self-checking bench for the register subset: host model on the bus,
 * integer reference of the registers, pin 0 outputs compared.
 * Assumes a pull-up on SDA; the bench resolves the wire.
 */
`timescale 1ns/10ps
module tb;
    logic clk, rstn, scl, host_oe_n, sda, sda_o, sda_oe_n, gp, sp;
    logic pout, poe_n, pup, pdn, ibuf, srst;
    int bad_count = 0;
    int cmp_count = 0;
    int srst_seen = 0;
    int ref_addr = scr_pkg::BUS_ADDR_DEFAULT;
    int ref_cfg = 8'h05;
    bit [31:0] rs = 19244;

    assign sda = !(!host_oe_n || (!sda_oe_n && !sda_o));

    scr_host_mdl HOST (.i_core_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(host_oe_n));
    scr_top DUT (.i_core_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda),
        .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .i_gpout0(gp), .i_signal_present0(sp),
        .o_pin0_out(pout), .o_pin0_oe_n(poe_n), .o_pin0_pullup(pup),
        .o_pin0_pulldown(pdn), .o_pin0_ibuf_en(ibuf), .o_soft_reset(srst));

    // ****************************************************************
    // clock, watchdog and helpers
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
        if (srst === 1'b1)
            srst_seen++;

    initial
    begin
        repeat (100000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    function automatic bit [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ****************************************************************
    // bus transfers and reference
    // ****************************************************************
    function automatic void ref_wr(input int p, input int d);
        if (p == 0)
            ref_addr = (d >> 1) & 8'h7F;
        if (p == 1 && d[0])
            ref_cfg = 8'h05;
        if (p == 2)
            ref_cfg = d & 8'hFF;
    endfunction

    function automatic logic [7:0] ref_reg(input int p);
        return 8'(p == 0 ? ref_addr << 1 : (p == 2 ? ref_cfg : 0));
    endfunction

    // optional second data byte goes to the next offset (pointer auto-increment)
    task automatic wr(input int a, input int p, input int d, input bit exp_ack,
        input int d2 = -1);
        bit ack;
        HOST.start();
        HOST.wbyte(8'(a << 1), ack);
        chk(8'(ack), 8'(exp_ack));
        if (ack)
        begin
            HOST.wbyte(8'(p), ack);
            HOST.wbyte(8'(d), ack);
            if (d2 >= 0)
                HOST.wbyte(8'(d2), ack);
        end
        HOST.stop();
        if (exp_ack)
        begin
            ref_wr(p, d);
            if (d2 >= 0)
                ref_wr(p + 1, d2);
        end
    endtask

    // two reads the first byte with a master acknowledge, then the next offset
    task automatic rd(input int a, input int p, input bit two = 1'b0);
        bit ack;
        logic [7:0] v;
        logic [7:0] w;
        HOST.start();
        HOST.wbyte(8'(a << 1), ack);
        HOST.wbyte(8'(p), ack);
        HOST.start();
        HOST.wbyte(8'((a << 1) | 1), ack);
        HOST.rbyte(!two, v);
        if (two)
            HOST.rbyte(1'b1, w);
        HOST.stop();
        chk(v, ref_reg(p));
        if (two)
            chk(w, ref_reg(p + 1));
    endtask

    task automatic pins();
        logic [3:0] m;
        logic o;
        m = 4'(ref_cfg >> 4);
        o = (m == 4'h0) ? gp : ((m == 4'h1) ? sp : 1'b0);
        chk({3'h0, pout, poe_n, pup, pdn, ibuf}, {3'h0, o, 1'(~ref_cfg[0]),
            1'(ref_cfg[3:2] == 2'h2), 1'(ref_cfg[3:2] == 2'h1), 1'(ref_cfg[1])});
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        logic [7:0] cfg;
        bit [31:0] r;
        int old;
        int n;
        rstn = 1'b0;
        gp = 1'b0;
        sp = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        rstn = 1'b1;
        repeat (2) @(posedge clk);
        #2;
        for (int p = 0; p < 3; p++)
            rd(ref_addr, p);
        pins();
        wr(ref_addr ^ 1, 2, 8'h30, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            cfg = 8'(rnd());
            if (i < 2)
                cfg[7:4] = 4'(i);
            cfg[3:2] = 2'(i);
            if (cfg[0])
                cfg[1] = 1'b0;
            wr(ref_addr, 2, cfg, 1'b1);
            r = rnd();
            gp = r[0];
            sp = r[9];
            rd(ref_addr, 2);
            pins();
        end
        wr(ref_addr, 1, 8'h01, 1'b1, 8'h1A);
        rd(ref_addr, 1, 1'b1);
        pins();
        old = ref_addr;
        wr(ref_addr, 0, 8'h66, 1'b1);
        wr(old, 2, 8'h00, 1'b0);
        rd(ref_addr, 0);
        wr(ref_addr, 2, 8'h30, 1'b1);
        n = srst_seen;
        wr(ref_addr, 1, 8'hFE, 1'b1);
        chk(8'(srst_seen - n), 8'h00);
        rd(ref_addr, 1);
        rd(ref_addr, 2);
        wr(ref_addr, 1, 8'h01, 1'b1);
        chk(8'(srst_seen - n), 8'h01);
        rd(ref_addr, 2);
        rd(ref_addr, 0);
        pins();
        wr(ref_addr, 7, 8'hFF, 1'b1);
        rd(ref_addr, 7);
        report_and_stop();
    end
endmodule
